// ### hw/pebc_blank_gate.sv
// Per-source edge detection with blanking suppression.
`timescale 1ns/1ps
`default_nettype none
module pebc_blank_gate
  import pebc_pkg::*;
#(
  parameter int NSRC = 5
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Sources and blanking controls
  input wire logic [NSRC-1:0] src_i,
  input wire logic [NSRC-1:0] sel_i,
  input wire logic window_i,
  // Gated events
  output logic [NSRC-1:0] rise_o,
  output logic [NSRC-1:0] fall_o
);

  logic [NSRC-1:0] prev_q, prev_d;
  logic [NSRC-1:0] rise_q, rise_d;
  logic [NSRC-1:0] fall_q, fall_d;

  // A selected source inside the window may raise neither kind of event.
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    always_comb begin
      prev_d[g] = src_i[g];
      rise_d[g] = src_i[g] && !prev_q[g] && !(sel_i[g] && window_i); // [RQ3] [RQ4] [RQ6]
      fall_d[g] = !src_i[g] && prev_q[g] && !(sel_i[g] && window_i); // [RQ3] [RQ4] [RQ6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else if (ce_i) begin
      prev_q <= prev_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule
`default_nettype wire

// ### hw/pebc_top.sv
// Edge blanking control: mode and blanked-source registers, windows and event gating.
`timescale 1ns/1ps
`default_nettype none
`include "pebc_consts.svh"

// ****************************************
// Functional notes
// ****************************************
// Functional notes
// RQ1 - Falling-edge blanking mode sits at bits 5-4: 00 off, 01 immediate, others reserved.
// RQ2 - Rising-edge blanking mode sits at bits 1-0: 00 off, 01 immediate, others reserved.
// RQ3 - Source bit 2 set blanks comparator 2 events for the blanking duration.
// RQ4 - Source bit 3 set blocks comparator 3 events during the blanking window.
// RQ5 - Unused bits in mode and source registers ignore writes and read zero.
// RQ6 - Bits 4, 1 and 7 blank comparator 4, comparator 1 and the input pin.

module pebc_top
  import pebc_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int CNT_W = 8
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Blanking triggers from the PWM timebase
  input wire logic rise_trig_i,
  input wire logic fall_trig_i,
  // Event sources
  input wire logic cmp1_synced_out_i,
  input wire logic cmp2_synced_out_i,
  input wire logic cmp3_synced_out_i,
  input wire logic cmp4_synced_out_i,
  input wire logic pwm_ext_input_pin_i,
  // Gated events and windows
  output logic [4:0] src_rise_event_o,
  output logic [4:0] src_fall_event_o,
  output logic rise_window_o,
  output logic fall_window_o
);

  // ****************************************
  // Bus front end
  // ****************************************
  pebc_reg_if rif ();

  pebc_wb_slave #(
    .ADR_W(ADR_W)
  ) u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .regs(rif.slave)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] mode_q, mode_d;
  logic [7:0] rsrc_q, rsrc_d;
  logic [CNT_W-1:0] rtime_q, rtime_d;
  logic [CNT_W-1:0] ftime_q, ftime_d;

  pebc_mode_t rise_blank_mode;
  pebc_mode_t fall_blank_mode;
  logic rise_blank_pin_sel;
  logic rise_blank_cmp1_sel;
  logic rise_blank_cmp2_sel;
  logic rise_blank_cmp3_sel;
  logic rise_blank_cmp4_sel;

  // Decode used by the write path; the read path decodes the index with its own case.
  function automatic logic idx_hit(input logic [2:0] idx, input logic [2:0] want);
    idx_hit = (idx == want);
  endfunction

  always_comb begin
    mode_d = mode_q;
    rsrc_d = rsrc_q;
    rtime_d = rtime_q;
    ftime_d = ftime_q;
    if (rif.wr_en) begin
      if (idx_hit(rif.idx, `PEBC_IDX_MODE)) begin
        mode_d = rif.wdata & `PEBC_MODE_MASK; // [RQ1] [RQ2] [RQ5]
      end
      if (idx_hit(rif.idx, `PEBC_IDX_RSRC)) begin
        rsrc_d = rif.wdata & `PEBC_RSRC_MASK; // [RQ5]
      end
      if (idx_hit(rif.idx, `PEBC_IDX_RTIME)) begin
        rtime_d = rif.wdata[CNT_W-1:0];
      end
      if (idx_hit(rif.idx, `PEBC_IDX_FTIME)) begin
        ftime_d = rif.wdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `PEBC_RST_MODE;
      rsrc_q <= `PEBC_RST_RSRC;
      rtime_q <= CNT_W'(`PEBC_RST_TIME);
      ftime_q <= CNT_W'(`PEBC_RST_TIME);
    end else if (ce_i) begin
      mode_q <= mode_d;
      rsrc_q <= rsrc_d;
      rtime_q <= rtime_d;
      ftime_q <= ftime_d;
    end
  end

  assign rise_blank_mode = pebc_mode_t'(mode_q[`PEBC_MODE_RISE_LSB +: 2]); // [RQ2]
  assign fall_blank_mode = pebc_mode_t'(mode_q[`PEBC_MODE_FALL_LSB +: 2]); // [RQ1]
  assign rise_blank_pin_sel = rsrc_q[`PEBC_RSRC_PIN_BIT]; // [RQ6]
  assign rise_blank_cmp4_sel = rsrc_q[`PEBC_RSRC_CMP4_BIT]; // [RQ6]
  assign rise_blank_cmp3_sel = rsrc_q[`PEBC_RSRC_CMP3_BIT]; // [RQ4]
  assign rise_blank_cmp2_sel = rsrc_q[`PEBC_RSRC_CMP2_BIT]; // [RQ3]
  assign rise_blank_cmp1_sel = rsrc_q[`PEBC_RSRC_CMP1_BIT]; // [RQ6]

  // ****************************************
  // Read mux
  // ****************************************
  logic [CNT_W-1:0] rcnt_q, rcnt_d;
  logic [CNT_W-1:0] fcnt_q, fcnt_d;
  logic rise_win;
  logic fall_win;

  // Unmapped indices read as zero, so the bus never sees undriven data.
  always_comb begin
    rif.rdata = 8'h00;
    unique case (rif.idx)
      `PEBC_IDX_MODE: begin
        rif.rdata = mode_q & `PEBC_MODE_MASK; // [RQ5]
      end
      `PEBC_IDX_RSRC: begin
        rif.rdata = rsrc_q & `PEBC_RSRC_MASK; // [RQ5]
      end
      `PEBC_IDX_RTIME: begin
        rif.rdata = 8'(rtime_q);
      end
      `PEBC_IDX_FTIME: begin
        rif.rdata = 8'(ftime_q);
      end
      `PEBC_IDX_STAT: begin
        rif.rdata[`PEBC_STAT_RWIN_BIT] = rise_win;
        rif.rdata[`PEBC_STAT_FWIN_BIT] = fall_win;
      end
      default: begin
        rif.rdata = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Blanking windows
  // ****************************************
  // Reserved mode codes behave as no blanking; a trigger inside a running window restarts it.
  always_comb begin
    rcnt_d = rcnt_q;
    fcnt_d = fcnt_q;
    if (rise_trig_i && rise_blank_mode == PEBC_BLANK_IMM) begin
      rcnt_d = rtime_q; // [RQ2]
    end else if (rcnt_q != '0) begin
      rcnt_d = rcnt_q - CNT_W'(1);
    end
    if (fall_trig_i && fall_blank_mode == PEBC_BLANK_IMM) begin
      fcnt_d = ftime_q; // [RQ1]
    end else if (fcnt_q != '0) begin
      fcnt_d = fcnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcnt_q <= '0;
      fcnt_q <= '0;
    end else if (ce_i) begin
      rcnt_q <= rcnt_d;
      fcnt_q <= fcnt_d;
    end
  end

  assign rise_win = (rcnt_q != '0);
  assign fall_win = (fcnt_q != '0);
  assign rise_window_o = rise_win;
  assign fall_window_o = fall_win;

  // ****************************************
  // Event gate
  // ****************************************
  logic [4:0] src_vec;
  logic [4:0] sel_vec;

  assign src_vec = {pwm_ext_input_pin_i, cmp4_synced_out_i, cmp3_synced_out_i,
                    cmp2_synced_out_i, cmp1_synced_out_i};
  assign sel_vec = {rise_blank_pin_sel, rise_blank_cmp4_sel, rise_blank_cmp3_sel,
                    rise_blank_cmp2_sel, rise_blank_cmp1_sel};

  pebc_blank_gate #(
    .NSRC(5)
  ) u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_i(src_vec),
    .sel_i(sel_vec),
    .window_i(rise_win),
    .rise_o(src_rise_event_o),
    .fall_o(src_fall_event_o)
  );

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_fall_arm;
    ce_i && fall_trig_i && fall_blank_mode == PEBC_BLANK_IMM && ftime_q != '0;
  endsequence

  sequence s_fall_open;
    fall_window_o && fcnt_q == $past(ftime_q);
  endsequence

  a_fall_window_open: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    s_fall_arm |=> s_fall_open)
    else $error("Falling window did not open with the programmed length.");

  a_rise_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    (ce_i && rcnt_q == '0 && rise_blank_mode != PEBC_BLANK_IMM) |=> !rise_window_o)
    else $error("Rising window opened while rising blanking was off.");

  a_cmp2_blanked: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
    (ce_i && rise_win && rsrc_q[`PEBC_RSRC_CMP2_BIT])
      |=> !src_rise_event_o[PEBC_SRC_CMP2] && !src_fall_event_o[PEBC_SRC_CMP2])
    else $error("Comparator 2 event passed during blanking.");

  a_cmp3_blanked: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    (ce_i && rise_win && rsrc_q[`PEBC_RSRC_CMP3_BIT])
      |=> !src_rise_event_o[PEBC_SRC_CMP3] && !src_fall_event_o[PEBC_SRC_CMP3])
    else $error("Comparator 3 event passed during blanking.");

  a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    wb_ack_o |-> (($past(rif.idx) == `PEBC_IDX_MODE) ? (wb_dat_o[7:6] == 2'b00 &&
      wb_dat_o[3:2] == 2'b00) : 1'b1) && (($past(rif.idx) == `PEBC_IDX_RSRC) ?
      (wb_dat_o[6:5] == 2'b00 && wb_dat_o[0] == 1'b0) : 1'b1))
    else $error("Unused register bit read as one.");

  a_pin_blanked: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (ce_i && rise_win && rsrc_q[`PEBC_RSRC_PIN_BIT] && $rose(pwm_ext_input_pin_i))
      |=> !src_rise_event_o[PEBC_SRC_PIN])
    else $error("Input pin event passed during blanking.");

  a_cmp1_passes: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (ce_i && !rsrc_q[`PEBC_RSRC_CMP1_BIT] && cmp1_synced_out_i && !u_gate.prev_q[0])
      |=> src_rise_event_o[PEBC_SRC_CMP1])
    else $error("Unblanked comparator 1 edge was lost.");

  sequence s_rise_arm;
    ce_i && rise_trig_i && rise_blank_mode == PEBC_BLANK_IMM && rtime_q != '0;
  endsequence

  sequence s_rise_open;
    rise_window_o && rcnt_q == $past(rtime_q);
  endsequence

  a_rise_window_open: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    s_rise_arm |=> s_rise_open)
    else $error("Rising window did not open with the programmed length.");

  a_fall_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    (ce_i && fcnt_q == '0 && fall_blank_mode != PEBC_BLANK_IMM) |=> !fall_window_o)
    else $error("Falling window opened while falling blanking was off.");

  a_cmp1_blanked: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (ce_i && rise_win && rsrc_q[`PEBC_RSRC_CMP1_BIT])
      |=> !src_rise_event_o[PEBC_SRC_CMP1] && !src_fall_event_o[PEBC_SRC_CMP1])
    else $error("Comparator 1 event passed during blanking.");

  a_cmp4_blanked: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (ce_i && rise_win && rsrc_q[`PEBC_RSRC_CMP4_BIT])
      |=> !src_rise_event_o[PEBC_SRC_CMP4] && !src_fall_event_o[PEBC_SRC_CMP4])
    else $error("Comparator 4 event passed during blanking.");

  // A frozen window must not shorten, or blanking would end early after a stall.
  a_hold_frozen: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    !ce_i |=> $stable(rcnt_q) && $stable(mode_q))
    else $error("State moved while the clock enable was low.");

endmodule
`default_nettype wire

// ### hw/pebc_wb_slave.sv
// Classic Wishbone slave front end with a registered acknowledge.
`timescale 1ns/1ps
`default_nettype none
module pebc_wb_slave
  import pebc_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register side
  pebc_reg_if.slave regs
);

  logic ack_q, ack_d;
  logic [7:0] dat_q, dat_d;
  logic take;

  // One access is taken per request; ack drops in the cycle after it was given.
  assign take = wb_cyc_i && wb_stb_i && !ack_q;
  assign regs.idx = wb_adr_i[4:2];
  assign regs.wdata = wb_dat_i[7:0];
  // Only the low byte lane holds data, so a write without it changes nothing.
  assign regs.wr_en = ce_i && take && wb_we_i && wb_sel_i[0];

  always_comb begin
    ack_d = take;
    dat_d = take ? regs.rdata : dat_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else if (ce_i) begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, dat_q};

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_q && ce_i) |=> !ack_q)
    else $error("Acknowledge held longer than one cycle.");

endmodule
`default_nettype wire

// ### shared/pebc_consts.svh
// Register offsets, field positions and reset values of the edge blanking control block.
`ifndef PEBC_CONSTS_SVH
`define PEBC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PEBC_OFS_MODE 8'h00
`define PEBC_OFS_RSRC 8'h04
`define PEBC_OFS_RTIME 8'h08
`define PEBC_OFS_FTIME 8'h0c
`define PEBC_OFS_STAT 8'h10

// ****************************************
// Register indices (byte offset divided by four)
// ****************************************
`define PEBC_IDX_MODE 3'h0
`define PEBC_IDX_RSRC 3'h1
`define PEBC_IDX_RTIME 3'h2
`define PEBC_IDX_FTIME 3'h3
`define PEBC_IDX_STAT 3'h4

// ****************************************
// Field positions
// ****************************************
`define PEBC_MODE_FALL_LSB 4
`define PEBC_MODE_RISE_LSB 0
`define PEBC_MODE_MASK 8'h33
`define PEBC_RSRC_PIN_BIT 7
`define PEBC_RSRC_CMP4_BIT 4
`define PEBC_RSRC_CMP3_BIT 3
`define PEBC_RSRC_CMP2_BIT 2
`define PEBC_RSRC_CMP1_BIT 1
`define PEBC_RSRC_MASK 8'h9e
`define PEBC_STAT_RWIN_BIT 0
`define PEBC_STAT_FWIN_BIT 1

// ****************************************
// Reset values
// ****************************************
`define PEBC_RST_MODE 8'h00
`define PEBC_RST_RSRC 8'h00
`define PEBC_RST_TIME 8'h00

`endif

// ### shared/pebc_pkg.sv
// Types shared by the edge blanking control block.
package pebc_pkg;

  // Two-bit blanking mode codes; the two upper codes are reserved and act as no blanking.
  typedef enum logic [1:0] {
    PEBC_BLANK_OFF = 2'b00,
    PEBC_BLANK_IMM = 2'b01,
    PEBC_BLANK_RSV2 = 2'b10,
    PEBC_BLANK_RSV3 = 2'b11
  } pebc_mode_t;

  // Source order of the event gate: pin on top, comparator 1 at the bottom.
  typedef enum logic [2:0] {
    PEBC_SRC_CMP1 = 3'h0,
    PEBC_SRC_CMP2 = 3'h1,
    PEBC_SRC_CMP3 = 3'h2,
    PEBC_SRC_CMP4 = 3'h3,
    PEBC_SRC_PIN = 3'h4
  } pebc_src_t;

endpackage

// ### shared/pebc_reg_if.sv
// Register access carrier between the bus slave and the blanking core.
`timescale 1ns/1ps
`default_nettype none
interface pebc_reg_if;
  logic wr_en;
  logic [2:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport regs (input wr_en, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ### verification/pebc_src_model.sv
// Model of the comparator outputs and the external input pin seen by the blanking block.
`timescale 1ns/1ps
`default_nettype none
module pebc_src_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels requested by the bench
  input wire logic [4:0] want_i,
  // Source levels, comparator 1 at bit 0 and the pin at bit 4
  output logic [4:0] lvl_o
);
  // The comparator outputs are already synchronized, so levels only move on a clock edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_o <= 5'h00;
    end else begin
      lvl_o <= want_i;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench of the edge blanking control block.
`timescale 1ns/1ps
`default_nettype none
`include "pebc_consts.svh"
module testbench;
  import pebc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic rtrig = 1'b0;
  logic ftrig = 1'b0;
  logic ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [4:0] want = 5'h00;
  logic [4:0] lvl;
  logic [4:0] rise_ev;
  logic [4:0] fall_ev;
  logic ack;
  logic rwin;
  logic fwin;
  int fail_count = 0;
  int num_checks = 0;
  int sel_bit [5] = '{1, 2, 3, 4, 7};

  pebc_src_model u_pebc_src_model (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .lvl_o(lvl));

  pebc_top u_pebc_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rise_trig_i(rtrig), .fall_trig_i(ftrig),
    .cmp1_synced_out_i(lvl[0]), .cmp2_synced_out_i(lvl[1]), .cmp3_synced_out_i(lvl[2]),
    .cmp4_synced_out_i(lvl[3]), .pwm_ext_input_pin_i(lvl[4]),
    .src_rise_event_o(rise_ev), .src_fall_event_o(fall_ev),
    .rise_window_o(rwin), .fall_window_o(fwin)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack and read data are taken at the edge where ack is seen high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rdat, {24'h0, exp});
  endtask

  // Pulses one trigger and follows its window cycle by cycle.
  task automatic win_chk(input logic r, input int len, input logic on);
    @(posedge clk_i);
    rtrig <= r;
    ftrig <= ~r;
    @(posedge clk_i);
    rtrig <= 1'b0;
    ftrig <= 1'b0;
    for (int i = 0; i <= len; i++) begin
      #1;
      chk({31'h0, r ? rwin : fwin}, {31'h0, on && (i < len)});
      @(posedge clk_i);
    end
  endtask

  task automatic collect(output logic [4:0] r, output logic [4:0] f);
    r = 5'h00;
    f = 5'h00;
    repeat (5) begin
      @(posedge clk_i);
      #1;
      r = r | rise_ev;
      f = f | fall_ev;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    reg_chk(`PEBC_OFS_MODE, 8'h00);
    reg_chk(`PEBC_OFS_RSRC, 8'h00);
  endtask

  // A low enable freezes the count, so the window outlasts its programmed length.
  task automatic t_freeze();
    wb(1'b1, `PEBC_OFS_MODE, 32'h01, 4'hf);
    wb(1'b1, `PEBC_OFS_RTIME, 32'h2, 4'hf);
    rise_pulse();
    ce <= 1'b0;
    repeat (6) begin
      @(posedge clk_i);
      #1;
      chk({31'h0, rwin}, 32'h1);
    end
    @(posedge clk_i);
    ce <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({31'h0, rwin}, 32'h1);
    @(posedge clk_i);
    #1;
    chk({31'h0, rwin}, 32'h0);
  endtask

  // A reset in mid-run closes a running window and clears the mode, source and rising time registers.
  task automatic t_rerst();
    wb(1'b1, `PEBC_OFS_RTIME, 32'h8, 4'hf);
    rise_pulse();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({31'h0, rwin}, 32'h0);
    reg_chk(`PEBC_OFS_MODE, `PEBC_RST_MODE);
    reg_chk(`PEBC_OFS_RSRC, `PEBC_RST_RSRC);
    reg_chk(`PEBC_OFS_RTIME, `PEBC_RST_TIME);
  endtask

  task automatic t_fields();
    wb(1'b1, `PEBC_OFS_MODE, 32'hffff_ffff, 4'hf);
    reg_chk(`PEBC_OFS_MODE, 8'h33);
    wb(1'b1, `PEBC_OFS_RSRC, 32'hffff_ffff, 4'hf);
    reg_chk(`PEBC_OFS_RSRC, 8'h9e);
    wb(1'b1, `PEBC_OFS_RSRC, 32'h0, 4'he);
    reg_chk(`PEBC_OFS_RSRC, 8'h9e);
    wb(1'b1, 8'h14, 32'hff, 4'hf);
    reg_chk(8'h14, 8'h00);
  endtask

  task automatic t_modes();
    wb(1'b1, `PEBC_OFS_RTIME, 32'h2, 4'hf);
    wb(1'b1, `PEBC_OFS_FTIME, 32'h3, 4'hf);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 4; c++) begin
        wb(1'b1, `PEBC_OFS_MODE, 32'(c << (4 * f)), 4'hf);
        reg_chk(`PEBC_OFS_MODE, 8'(c << (4 * f)));
        win_chk(f == 0, 2 + f, c == 1);
      end
    end
  endtask

  // One trigger pulse; returns at the edge where the design has taken it.
  task automatic rise_pulse();
    @(posedge clk_i);
    rtrig <= 1'b1;
    @(posedge clk_i);
    rtrig <= 1'b0;
  endtask

  // Waits, at most 20 cycles, for the rising window to close.
  task automatic win_end();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rwin !== 1'b0 && n < 20);
    chk({31'h0, rwin}, 32'h0);
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
  endtask

  // Each selected source is silenced inside the window while its neighbour still fires.
  task automatic t_blank();
    int j;
    logic [4:0] r;
    logic [4:0] f;
    wb(1'b1, `PEBC_OFS_MODE, 32'h01, 4'hf);
    wb(1'b1, `PEBC_OFS_RTIME, 32'h8, 4'hf);
    for (int i = 0; i < 5; i++) begin
      j = (i + 1) % 5;
      wb(1'b1, `PEBC_OFS_RSRC, 32'(1 << sel_bit[i]), 4'hf);
      rise_pulse();
      want <= 5'(1 << i) | 5'(1 << j);
      collect(r, f);
      chk({27'h0, r}, 32'(1 << j));
      rise_pulse();
      want <= 5'h00;
      collect(r, f);
      chk({27'h0, f}, 32'(1 << j));
      chk({27'h0, r}, 32'h0);
      win_end();
      want <= 5'(1 << i) | 5'(1 << j);
      collect(r, f);
      chk({27'h0, r}, 32'(1 << i) | 32'(1 << j));
      @(posedge clk_i);
      want <= 5'h00;
      collect(r, f);
      chk({27'h0, f}, 32'(1 << i) | 32'(1 << j));
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_modes();
    t_blank();
    t_freeze();
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
